/* File: src/power_state_manager.sv */
// Power state manager: activity status, power state with test bits, scratch.
// Assumes an index/data port pair strobed synchronously, and timer and
// activity events delivered as one-cycle pulses from outside.
`timescale 1ns/100ps
module power_state_manager #(
   parameter int unsigned US_DIV  = power_state_pkg::US_CYCLES,
   parameter int unsigned MS_DIV  = power_state_pkg::MS_PER_US,
   parameter int unsigned S_DIV   = power_state_pkg::S_PER_MS,
   parameter int unsigned MIN_DIV = power_state_pkg::MIN_PER_S
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         resetn,
   // Indexed register port
   input  wire logic         io_sel_data,
   input  wire logic         io_wr,
   input  wire logic         io_rd,
   input  wire logic [7:0]   io_wdata,
   output logic      [7:0]   io_rdata_r,
   output logic              io_hit_r,
   // Activity events
   input  wire logic         upper_interrupt_lines_activity,
   input  wire logic         timer_interrupt_line_activity,
   input  wire logic         nmi_activity,
   input  wire logic [2:0]   activity_enable,
   input  wire logic         system_activity,
   input  wire logic         housekeeping_activity,
   // Timer expiry pulses
   input  wire logic         doze_timeout,
   input  wire logic         standby_timeout,
   input  wire logic         housekeeping_timeout,
   // SMI control register contents
   input  wire logic [7:0]   smi_control,
   // State and SMI
   output logic      [2:0]   power_state_r,
   output logic              smi_r,
   output logic              clear_enabled_activity_r,
   // Time base ticks
   output logic      [3:0]   tick_r
);
   power_state_pkg::pstate_type state_r, state_nxt, auto_tgt;
   logic [7:0] index_r, index_nxt;
   logic [2:0] act_r, act_nxt;
   logic [3:0] test_r, test_nxt;
   logic [7:0] scratch_r, scratch_nxt;
   logic [7:0] rdata_nxt;
   logic       hit_nxt;
   logic [2:0] code_nxt;
   logic       smi_nxt, clr_nxt;
   logic       auto_go, smi_req;
   logic       data_wr, sw_state_wr;
   logic [2:0] events;
   logic [3:0] test_mode;

   assign data_wr     = io_wr && io_sel_data;
   assign sw_state_wr = data_wr && (index_r == power_state_pkg::IDX_POWER);
   assign events      = {upper_interrupt_lines_activity, timer_interrupt_line_activity, nmi_activity};
   assign test_mode   = {test_r[0], test_r[1], test_r[2], test_r[3]};

   // Automatic target and SMI substitution per state
   always_comb
   begin
      auto_go  = 1'b0;
      smi_req  = 1'b0;
      auto_tgt = state_r;
      case (state_r)
         power_state_pkg::st_on:
         begin
            if (standby_timeout)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_STBY_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_standby;
            end
            else if (doze_timeout)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_DOZE_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_doze;
            end
         end
         power_state_pkg::st_doze:
         begin
            if (system_activity)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_ACT_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_on;
            end
            else if (standby_timeout)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_STBY_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_standby;
            end
            else if (housekeeping_activity)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_HK_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_doze_hk;
            end
         end
         power_state_pkg::st_standby:
         begin
            if (system_activity)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_ACT_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_on;
            end
            else if (housekeeping_activity)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_HK_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_standby_hk;
            end
         end
         power_state_pkg::st_doze_hk, power_state_pkg::st_standby_hk:
         begin
            if (system_activity)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_ACT_BIT];
               auto_go  = !smi_req;
               auto_tgt = power_state_pkg::st_on;
            end
            else if (housekeeping_timeout)
            begin
               smi_req  = smi_control[power_state_pkg::SMI_HKTO_BIT];
               auto_go  = !smi_req;
               auto_tgt = (state_r == power_state_pkg::st_doze_hk) ?
                          power_state_pkg::st_doze : power_state_pkg::st_standby;
            end
         end
         // Suspend has no automatic exit or entry
         power_state_pkg::st_suspend: auto_go = 1'b0;
         default: auto_go = 1'b0;
      endcase
   end

   // Next register values
   always_comb
   begin
      index_nxt   = index_r;
      act_nxt     = act_r;
      test_nxt    = test_r;
      scratch_nxt = scratch_r;
      state_nxt   = state_r;
      smi_nxt     = smi_r;
      clr_nxt     = 1'b0;
      rdata_nxt   = io_rdata_r;
      hit_nxt     = io_hit_r;
      if (io_wr && !io_sel_data)
         index_nxt = io_wdata;
      if (data_wr && index_r == power_state_pkg::IDX_ACTIVITY)
         act_nxt = act_r & ~io_wdata[power_state_pkg::ACT_UPPER_BIT:power_state_pkg::ACT_NMI_BIT];
      if (data_wr && index_r == power_state_pkg::IDX_SCRATCH)
         scratch_nxt = io_wdata;
      if (sw_state_wr)
      begin
         test_nxt = io_wdata[power_state_pkg::TEST_US_BIT:power_state_pkg::TEST_MIN_BIT];
         case (io_wdata[power_state_pkg::STATE_MSB:0])
            power_state_pkg::CODE_ON:         state_nxt = power_state_pkg::st_on;
            power_state_pkg::CODE_DOZE:       state_nxt = power_state_pkg::st_doze;
            power_state_pkg::CODE_STANDBY:    state_nxt = power_state_pkg::st_standby;
            power_state_pkg::CODE_SUSPEND:    state_nxt = power_state_pkg::st_suspend;
            power_state_pkg::CODE_DOZE_HK:    state_nxt = power_state_pkg::st_doze_hk;
            power_state_pkg::CODE_STANDBY_HK: state_nxt = power_state_pkg::st_standby_hk;
            default:                          state_nxt = state_r;
         endcase
      end
      else if (auto_go && !smi_r)
      begin
         state_nxt = auto_tgt;
         if (auto_tgt == power_state_pkg::st_doze || auto_tgt == power_state_pkg::st_standby)
         begin
            act_nxt = act_nxt & ~activity_enable;
            clr_nxt = 1'b1;
         end
      end
      // New events win over any clear in the same cycle
      act_nxt = act_nxt | events;
      // Pending SMI clears on a state write even with a new request; a request sets it only when none is pending
      smi_nxt = (smi_req && !smi_r) || (smi_r && !sw_state_wr);
      if (io_rd && io_sel_data)
      begin
         hit_nxt = 1'b1;
         case (index_r)
            power_state_pkg::IDX_ACTIVITY: rdata_nxt = {act_r, 5'h00};
            power_state_pkg::IDX_POWER:    rdata_nxt = {1'b0, test_r, power_state_r};
            power_state_pkg::IDX_SCRATCH:  rdata_nxt = scratch_r;
            default:
            begin
               rdata_nxt = power_state_pkg::REG_RESET;
               hit_nxt   = 1'b0;
            end
         endcase
      end
      case (state_nxt)
         power_state_pkg::st_on:         code_nxt = power_state_pkg::CODE_ON;
         power_state_pkg::st_doze:       code_nxt = power_state_pkg::CODE_DOZE;
         power_state_pkg::st_standby:    code_nxt = power_state_pkg::CODE_STANDBY;
         power_state_pkg::st_suspend:    code_nxt = power_state_pkg::CODE_SUSPEND;
         power_state_pkg::st_doze_hk:    code_nxt = power_state_pkg::CODE_DOZE_HK;
         power_state_pkg::st_standby_hk: code_nxt = power_state_pkg::CODE_STANDBY_HK;
         default:                        code_nxt = power_state_pkg::CODE_ON;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         index_r                  <= power_state_pkg::REG_RESET;
         act_r                    <= 3'h0;
         test_r                   <= 4'h0;
         scratch_r                <= power_state_pkg::REG_RESET;
         state_r                  <= power_state_pkg::st_on;
         power_state_r            <= power_state_pkg::CODE_ON;
         smi_r                    <= 1'b0;
         clear_enabled_activity_r <= 1'b0;
         io_rdata_r               <= power_state_pkg::REG_RESET;
         io_hit_r                 <= 1'b0;
      end
      else
      begin
         index_r                  <= index_nxt;
         act_r                    <= act_nxt;
         test_r                   <= test_nxt;
         scratch_r                <= scratch_nxt;
         state_r                  <= state_nxt;
         power_state_r            <= code_nxt;
         smi_r                    <= smi_nxt;
         clear_enabled_activity_r <= clr_nxt;
         io_rdata_r               <= rdata_nxt;
         io_hit_r                 <= hit_nxt;
      end
   end

   // Test bits select per-clock ticking
   time_base #(
      .CW   (16),
      .DIVS ('{US_DIV, MS_DIV, S_DIV, MIN_DIV})
   ) u_time_base (
      .clock     (clock),
      .resetn    (resetn),
      .test_mode (test_mode),
      .tick_r    (tick_r)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_reset_clear;
      !resetn |=> act_r == 3'h0 && scratch_r == 8'h00 && power_state_r == 3'h0;
   endproperty
   a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("reset values wrong");
   property p_upper_set;
      upper_interrupt_lines_activity |=> act_r[2];
   endproperty
   a_upper_set: assert property (p_upper_set) else $error("upper activity not recorded");
   property p_nmi_sticky;
      act_r[0] && !data_wr && !clr_nxt |=> act_r[0];
   endproperty
   a_nmi_sticky: assert property (p_nmi_sticky) else $error("status bit lost");
   property p_code_valid;
      power_state_r != 3'h4 && power_state_r != 3'h7;
   endproperty
   a_code_valid: assert property (p_code_valid) else $error("reserved state code");
   property p_doze_auto;
      state_r == power_state_pkg::st_on && doze_timeout && !standby_timeout && !smi_r &&
      !sw_state_wr && !smi_control[power_state_pkg::SMI_DOZE_BIT] |=> power_state_r == power_state_pkg::CODE_DOZE;
   endproperty
   a_doze_auto: assert property (p_doze_auto) else $error("doze not entered");
   property p_doze_smi;
      state_r == power_state_pkg::st_on && doze_timeout && !standby_timeout && !sw_state_wr &&
      smi_control[power_state_pkg::SMI_DOZE_BIT] |=> smi_r && power_state_r == power_state_pkg::CODE_ON;
   endproperty
   a_doze_smi: assert property (p_doze_smi) else $error("doze SMI missing");
   property p_no_auto_suspend;
      power_state_r == 3'h3 && $past(power_state_r) != 3'h3 |-> $past(sw_state_wr);
   endproperty
   a_no_auto_suspend: assert property (p_no_auto_suspend) else $error("suspend entered by hardware");
   property p_smi_drop;
      sw_state_wr && !smi_req |-> ##[1:3] !smi_r;
   endproperty
   a_smi_drop: assert property (p_smi_drop) else $error("SMI held too long");
   property p_smi_hold;
      smi_r && !sw_state_wr |=> $stable(power_state_r);
   endproperty
   a_smi_hold: assert property (p_smi_hold) else $error("state moved during SMI");
   property p_scratch;
      data_wr && index_r == power_state_pkg::IDX_SCRATCH |=> scratch_r == $past(io_wdata);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch write lost");
   property p_us_test;
      test_r[3] [*2] |-> tick_r[0];
   endproperty
   a_us_test: assert property (p_us_test) else $error("us test tick missing");

   c_doze: cover property (power_state_r == 3'h0 ##1 power_state_r == 3'h1);
   c_smi: cover property (smi_r ##[1:20] !smi_r);
   c_hk_back: cover property (power_state_r == 3'h5 ##1 power_state_r == 3'h1);
endmodule // power_state_manager

/* File: src/power_state_pkg.sv */
// Constants and types shared by the power state manager and its time base.
// Assumes a 200 MHz clock and byte-wide indexed register access.
package power_state_pkg;
   // Register indexes behind the data port
   localparam logic [7:0] IDX_ACTIVITY = 8'h79;
   localparam logic [7:0] IDX_POWER    = 8'h7a;
   localparam logic [7:0] IDX_SCRATCH  = 8'h7b;
   localparam logic [7:0] REG_RESET    = 8'h00;
   // Activity status fields
   localparam int ACT_UPPER_BIT = 7;
   localparam int ACT_TIMER_BIT = 6;
   localparam int ACT_NMI_BIT   = 5;
   // Power register fields
   localparam int TEST_US_BIT  = 6;
   localparam int TEST_MIN_BIT = 3;
   localparam int STATE_MSB    = 2;
   // State codes
   localparam logic [2:0] CODE_ON         = 3'h0;
   localparam logic [2:0] CODE_DOZE       = 3'h1;
   localparam logic [2:0] CODE_STANDBY    = 3'h2;
   localparam logic [2:0] CODE_SUSPEND    = 3'h3;
   localparam logic [2:0] CODE_DOZE_HK    = 3'h5;
   localparam logic [2:0] CODE_STANDBY_HK = 3'h6;
   // SMI control fields
   localparam int SMI_DOZE_BIT  = 7;
   localparam int SMI_STBY_BIT  = 6;
   localparam int SMI_HK_BIT    = 4;
   localparam int SMI_HKTO_BIT  = 3;
   localparam int SMI_ACT_BIT   = 2;
   // Time base
   localparam int CLK_NS        = 5;
   localparam int US_NS         = 1000;
   localparam int US_CYCLES     = US_NS / CLK_NS;
   localparam int MS_PER_US     = 1000;
   localparam int S_PER_MS      = 1000;
   localparam int MIN_PER_S     = 60;
   localparam int SMI_DROP_MAX  = 3;
   typedef enum logic [2:0] {
      st_on, st_doze, st_standby, st_suspend, st_doze_hk, st_standby_hk
   } pstate_type;
endpackage

/* File: src/time_base.sv */
// Chain of four dividers making microsecond, millisecond, second, minute ticks.
// Each stage can be forced to tick on every clock by its test bit.
`timescale 1ns/100ps
module time_base #(
   parameter int unsigned CW        = 16,
   parameter int unsigned DIVS [4]  = '{power_state_pkg::US_CYCLES, power_state_pkg::MS_PER_US,
                                        power_state_pkg::S_PER_MS, power_state_pkg::MIN_PER_S}
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         resetn,
   // Test bits, index 0 is microseconds
   input  wire logic [3:0]   test_mode,
   // Registered ticks, index 0 is microseconds
   output logic      [3:0]   tick_r
);
   logic [3:0] tick_nxt;
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_stage
         logic [CW-1:0] cnt_r;
         logic [CW-1:0] cnt_nxt;
         logic          adv;
         assign adv = (i == 0) ? 1'b1 : tick_r[(i == 0) ? 0 : i-1];
         always_comb
         begin
            cnt_nxt     = cnt_r;
            tick_nxt[i] = 1'b0;
            if (test_mode[i])
            begin
               cnt_nxt     = '0;
               tick_nxt[i] = 1'b1;
            end
            else if (adv)
            begin
               if (cnt_r == CW'(DIVS[i] - 1))
               begin
                  cnt_nxt     = '0;
                  tick_nxt[i] = 1'b1;
               end
               else
                  cnt_nxt = cnt_r + CW'(1);
            end
         end
         always_ff @(posedge clock)
         begin
            if (!resetn)
            begin
               cnt_r     <= '0;
               tick_r[i] <= 1'b0;
            end
            else
            begin
               cnt_r     <= cnt_nxt;
               tick_r[i] <= tick_nxt[i];
            end
         end
      end
   endgenerate
endmodule // time_base

/* File: verification/host_port_model.sv */
// Host software model driving the indexed register port of the manager.
// Assumes the bench calls its tasks; signals change 1 ns after a rising edge.
`timescale 1ns/100ps
module host_port_model (
   // Clock
   input  wire logic       clock,
   // Register port
   output logic            io_sel_data,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata_r,
   input  wire logic       io_hit_r
);
   initial
   begin
      io_sel_data = 1'b0;
      io_wr       = 1'b0;
      io_rd       = 1'b0;
      io_wdata    = 8'h00;
   end

   // One strobe cycle, then data line shows the inverse
   task automatic access(input logic sel, input logic wr, input logic [7:0] d);
      @(posedge clock);
      #1;
      io_sel_data = sel;
      io_wr       = wr;
      io_rd       = ~wr;
      io_wdata    = d;
      @(posedge clock);
      #1;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
      io_wdata = ~d;
   endtask

   // Any defined state code may be written at any time
   task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
      access(1'b0, 1'b1, idx);
      access(1'b1, 1'b1, d);
   endtask

   task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic hit);
      access(1'b0, 1'b1, idx);
      access(1'b1, 1'b0, 8'h00);
      d   = io_rdata_r;
      hit = io_hit_r;
   endtask

   // Test bits put back to zero after each factory
   task automatic leave_test_mode();
      write_reg(power_state_pkg::IDX_POWER, 8'h00);
   endtask
endmodule // host_port_model

/* File: verification/power_state_manager_bench.sv */
// Bench for the power state manager: registers, state moves, SMI, time base.
// Assumes the host model drives the register port; events come from here.
`timescale 1ns/100ps
module power_state_manager_bench;
   localparam logic [7:0] EV_DTO = 8'h01, EV_STO = 8'h02, EV_HKTO = 8'h04, EV_HK = 8'h08;
   localparam logic [7:0] EV_SYS = 8'h10, EV_NMI = 8'h20, EV_TMR = 8'h40, EV_UP = 8'h80;
   localparam logic [7:0] ACT = power_state_pkg::IDX_ACTIVITY;
   localparam logic [7:0] PWR = power_state_pkg::IDX_POWER;
   localparam logic [7:0] SCR = power_state_pkg::IDX_SCRATCH;
   localparam int         LIMIT = 6000;
   logic       clock = 1'b0;
   logic       resetn = 1'b0;
   logic       io_sel_data, io_wr, io_rd, io_hit_r, smi_r, clear_enabled_activity_r;
   logic [7:0] io_wdata, io_rdata_r;
   logic [7:0] events = 8'h00;
   logic [7:0] smi_control = 8'h00;
   logic [2:0] activity_enable = 3'b000;
   logic [2:0] power_state_r;
   logic [3:0] tick_r;
   logic [7:0] cnt [4];
   int         num_errors = 0;
   int         comparisons = 0;
   int         cycles = 0;
   logic [7:0] aev [14] = '{EV_HK, EV_HKTO, EV_HK, EV_SYS, EV_STO, EV_HK, EV_HKTO, EV_HK, EV_SYS,
                            EV_DTO, EV_STO, EV_SYS, EV_DTO, EV_SYS};
   logic [2:0] ast [14] = '{3'h5, 3'h1, 3'h5, 3'h0, 3'h2, 3'h6, 3'h2, 3'h6, 3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h0};
   logic [2:0] sst [10] = '{3'h0, 3'h1, 3'h1, 3'h5, 3'h5, 3'h0, 3'h2, 3'h2, 3'h6, 3'h6};
   logic [7:0] sev [10] = '{EV_DTO, EV_SYS, EV_HK, EV_HKTO, EV_SYS, EV_STO, EV_SYS, EV_HK, EV_HKTO, EV_SYS};
   int         sbit [10] = '{7, 2, 4, 3, 2, 6, 2, 4, 3, 2};
   logic [2:0] stgt [10] = '{3'h1, 3'h0, 3'h5, 3'h1, 3'h0, 3'h2, 3'h0, 3'h6, 3'h2, 3'h0};
   logic [7:0] nat [4] = '{8'h12, 8'h06, 8'h02, 8'h01};

   always #2.5 clock = ~clock;

   power_state_manager #(.US_DIV(4), .MS_DIV(3), .S_DIV(3), .MIN_DIV(2)) dut (
      .clock(clock), .resetn(resetn), .io_sel_data(io_sel_data), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_hit_r(io_hit_r),
      .upper_interrupt_lines_activity(events[7]), .timer_interrupt_line_activity(events[6]),
      .nmi_activity(events[5]), .activity_enable(activity_enable), .system_activity(events[4]),
      .housekeeping_activity(events[3]), .doze_timeout(events[0]), .standby_timeout(events[1]),
      .housekeeping_timeout(events[2]), .smi_control(smi_control), .power_state_r(power_state_r),
      .smi_r(smi_r), .clear_enabled_activity_r(clear_enabled_activity_r), .tick_r(tick_r));

   host_port_model host (
      .clock(clock), .io_sel_data(io_sel_data), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_hit_r(io_hit_r));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_check(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      logic       h;
      host.read_reg(idx, d, h);
      check(what, d, exp);
      check({what, " hit"}, {7'h00, h}, {7'h00, (idx inside {ACT, PWR, SCR})});
   endtask

   task automatic chk_state(input string what, input logic [2:0] s, input logic m);
      check(what, {5'h00, power_state_r}, {5'h00, s});
      check({what, " smi"}, {7'h00, smi_r}, {7'h00, m});
   endtask

   task automatic pulse(input logic [7:0] e);
      @(posedge clock);
      #1;
      events = e;
      @(posedge clock);
      #1;
      events = 8'h00;
   endtask

   task automatic count_ticks(input int n);
      cnt = '{8'h00, 8'h00, 8'h00, 8'h00};
      repeat (n)
      begin
         @(posedge clock);
         #1;
         for (int k = 0; k < 4; k++)
            cnt[k] = cnt[k] + {7'h00, tick_r[k]};
      end
   endtask

   task automatic reset_dut();
      @(posedge clock);
      #1;
      resetn = 1'b0;
      repeat (20) @(posedge clock);
      #1;
      resetn = 1'b1;
   endtask

   task automatic end_test(input string name);
      $display("Test %s done, mismatches so far %0d", name, num_errors);
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         num_errors++;
         print_verdict();
      end
   end

   initial
   begin
      reset_dut();
      rd_check("status reset", ACT, 8'h00);
      rd_check("power reset", PWR, 8'h00);
      rd_check("scratch reset", SCR, 8'h00);
      end_test("reset");
      host.write_reg(SCR, 8'ha5);
      rd_check("scratch", SCR, 8'ha5);
      host.write_reg(8'h7c, 8'h3c);
      rd_check("unmapped", 8'h7c, 8'h00);
      rd_check("scratch kept", SCR, 8'ha5);
      end_test("scratch");
      pulse(EV_UP);
      rd_check("upper lines", ACT, 8'h80);
      pulse(EV_TMR);
      rd_check("timer line", ACT, 8'hc0);
      pulse(EV_NMI);
      rd_check("nmi", ACT, 8'he0);
      host.write_reg(ACT, 8'h9f);
      rd_check("clear one", ACT, 8'h60);
      activity_enable = 3'b101;
      pulse(EV_UP | EV_DTO);
      check("clear pulse", {7'h00, clear_enabled_activity_r}, 8'h01);
      chk_state("auto doze", 3'h1, 1'b0);
      // Bit 5 cleared by the move; bit 7 set again by the event in the same cycle
      rd_check("auto clear", ACT, 8'hc0);
      host.write_reg(ACT, 8'hff);
      rd_check("clear all", ACT, 8'h00);
      end_test("activity");
      foreach (aev[i])
      begin
         pulse(aev[i]);
         chk_state("auto move", ast[i], 1'b0);
         rd_check("power code", PWR, {5'h00, ast[i]});
      end
      end_test("auto moves");
      foreach (sst[i])
      begin
         smi_control = 8'h00;
         host.write_reg(PWR, {5'h00, sst[i]});
         smi_control = 8'h01 << sbit[i];
         pulse(sev[i]);
         chk_state("smi raised", sst[i], 1'b1);
         pulse(sev[i] | EV_STO);
         chk_state("smi hold", sst[i], 1'b1);
         host.write_reg(PWR, {5'h00, stgt[i]});
         chk_state("software move", stgt[i], 1'b0);
      end
      end_test("smi");
      smi_control = 8'h00;
      host.write_reg(PWR, 8'h03);
      foreach (aev[i])
         pulse(aev[i]);
      chk_state("suspend held", 3'h3, 1'b0);
      host.write_reg(PWR, 8'h07);
      rd_check("reserved code", PWR, 8'h03);
      host.write_reg(PWR, 8'h00);
      end_test("suspend");
      count_ticks(72);
      foreach (nat[k])
         check("normal ticks", cnt[k], nat[k]);
      for (int k = 0; k < 4; k++)
      begin
         host.write_reg(PWR, 8'h40 >> k);
         rd_check("test bit", PWR, 8'h40 >> k);
         count_ticks(8);
         check("test ticks", cnt[k], 8'h08);
         host.leave_test_mode();
      end
      end_test("time base");
      host.write_reg(SCR, 8'h5a);
      host.write_reg(PWR, 8'h02);
      pulse(EV_NMI);
      reset_dut();
      chk_state("second reset", 3'h0, 1'b0);
      rd_check("status reset", ACT, 8'h00);
      rd_check("power reset", PWR, 8'h00);
      rd_check("scratch reset", SCR, 8'h00);
      end_test("second reset");
      print_verdict();
   end
endmodule // power_state_manager_bench
